// file: bench/tb_top.sv
// Self-checking bench for the reset sequencer software control block
`timescale 1ns/1ps
module tb_top;
    import rsqsw_pkg::*;
    localparam int LIMIT = 20000;
    logic              ref_clk = 1'b0;
    logic              srst    = 1'b1;
    logic [RSQ_AW-1:0] addr    = 8'h00;
    logic [RSQ_DW-1:0] wdata   = 32'h0000_0000;
    logic              wr      = 1'b0;
    logic              rd      = 1'b0;
    logic [RSQ_DW-1:0] rdata;
    logic [9:0]        src     = 10'h000;
    logic [9:0]        rst_out;
    logic              irq;
    int                bad_count   = 0;
    int                comparisons = 0;
    int                cyc         = 0;

    rsqsw_top #(
        .STEP_CYCS (2)
    ) DUT (
        .REF_CLK                (ref_clk),
        .SRST                   (srst),
        .ADDR                   (addr),
        .WDATA                  (wdata),
        .WR                     (wr),
        .RD                     (rd),
        .RDATA                  (rdata),
        .INDEXED_RESET_SOURCE   (src),
        .SEQUENCED_RESET_OUTPUT (rst_out),
        .IRQ                    (irq)
    );

    always #2 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge ref_clk);
        chk(d, exp);
    endtask

    task automatic wait_out(input logic [9:0] exp, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (rst_out === exp) break;
        end
        @(posedge ref_clk);
        chk({22'h0, rst_out}, {22'h0, exp});
    endtask

    task automatic wait_irq(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge ref_clk);
            #1;
            if (irq === 1'b1) break;
        end
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0001);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        // Reset values, read-only and unmapped places
        rd_chk(OFS_BRINGUP, 32'h0000_03FF);
        rd_chk(OFS_STATUS, 32'h0000_0001);
        rd_chk(OFS_OVERRIDE, 32'h0000_0000);
        rd_chk(OFS_MASK, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_0000);
        wr_reg(OFS_STATUS, 32'h0000_0000);
        rd_chk(OFS_STATUS, 32'h0000_0001);
        wr_reg(OFS_STATUS, 32'hFFFF_FFFF);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        $display("test registers done");
        // Direct override with per-bit triggers
        wr_reg(OFS_OVERRIDE, 32'h0003_0003);
        chk({22'h0, rst_out}, 32'h0000_0003);
        wr_reg(OFS_OVERRIDE, 32'h0001_0002);
        chk({22'h0, rst_out}, 32'h0000_0002);
        wr_reg(OFS_OVERRIDE, 32'h0202_0200);
        chk({22'h0, rst_out}, 32'h0000_0200);
        rd_chk(OFS_OVERRIDE, 32'h0000_0000);
        $display("test override done");
        // Software trigger, masking, stepped bring-up at index 0
        wr_reg(OFS_MASK, 32'h0000_0201);
        wr_reg(OFS_BRINGUP, 32'h0000_0001);
        wr_reg(OFS_IRQ_EN, 32'h2000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        wr_reg(OFS_CONTROL, 32'h0000_0003);
        wait_irq(300);
        chk({22'h0, rst_out}, 32'h0000_03FE);
        rd_chk(OFS_STATUS, 32'hA000_0000);
        repeat (20) @(posedge ref_clk);
        chk({22'h0, rst_out}, 32'h0000_03FE);
        wr_reg(OFS_STATUS, 32'h2000_0000);
        wait_out(10'h000, 300);
        repeat (4) @(posedge ref_clk);
        rd_chk(OFS_STATUS, 32'h0000_0002);
        wr_reg(OFS_STATUS, 32'h0000_0002);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        $display("test sw trigger done");
        // Stepped entry with two selected outputs
        wr_reg(OFS_MASK, 32'h0000_0000);
        wr_reg(OFS_ENTRY_EN, 32'h0000_0003);
        wr_reg(OFS_IRQ_EN, 32'h4000_0000);
        wr_reg(OFS_CONTROL, 32'h0000_0004);
        rd_chk(OFS_CONTROL, 32'h0000_0004);
        rd_chk(OFS_STATUS, 32'h0000_0000);
        wr_reg(OFS_CONTROL, 32'h0000_0005);
        wait_irq(100);
        chk({22'h0, rst_out}, 32'h0000_0001);
        rd_chk(OFS_STATUS, 32'hC000_0000);
        repeat (10) @(posedge ref_clk);
        chk({22'h0, rst_out}, 32'h0000_0001);
        wr_reg(OFS_STATUS, 32'h4000_0000);
        wait_out(10'h003, 50);
        rd_chk(OFS_STATUS, 32'hC000_0000);
        chk({31'h0, irq}, 32'h0000_0001);
        wr_reg(OFS_STATUS, 32'h4000_0000);
        wait_out(10'h3FF, 50);
        wait_out(10'h000, 300);
        repeat (4) @(posedge ref_clk);
        rd_chk(OFS_STATUS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        wr_reg(OFS_STATUS, 32'hFFFF_FFFF);
        $display("test stepped entry done");
        // Hardware source with a mask, interrupt enabled late
        wr_reg(OFS_CONTROL, 32'h0000_0000);
        wr_reg(OFS_MASK, 32'h0000_0004);
        wr_reg(OFS_IRQ_EN, 32'h0000_0000);
        src <= 10'h008;
        wait_out(10'h3FB, 300);
        rd_chk(OFS_STATUS, 32'h8000_0020);
        chk({31'h0, irq}, 32'h0000_0000);
        wr_reg(OFS_IRQ_EN, 32'h0000_0020);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        repeat (10) @(posedge ref_clk);
        chk({22'h0, rst_out}, 32'h0000_03FB);
        src <= 10'h000;
        wait_out(10'h000, 300);
        repeat (4) @(posedge ref_clk);
        rd_chk(OFS_STATUS, 32'h0000_0020);
        wr_reg(OFS_STATUS, 32'h0000_0020);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test hardware source done");
        report_and_stop();
    end
endmodule

// file: hdl/rsqsw_pkg.sv
// Register map, field layout and timing constants of the reset sequencer
package rsqsw_pkg;
    localparam int          RSQ_NRST      = 10;
    localparam int          RSQ_AW        = 8;
    localparam int          RSQ_DW        = 32;
    localparam logic [7:0]  OFS_STATUS    = 8'h00;
    localparam logic [7:0]  OFS_IRQ_EN    = 8'h04;
    localparam logic [7:0]  OFS_CONTROL   = 8'h08;
    localparam logic [7:0]  OFS_ENTRY_EN  = 8'h0C;
    localparam logic [7:0]  OFS_BRINGUP   = 8'h10;
    localparam logic [7:0]  OFS_OVERRIDE  = 8'h14;
    localparam logic [7:0]  OFS_MASK      = 8'h18;
    localparam int          ST_ACTIVE     = 31;
    localparam int          ST_AWAIT      = 30;
    localparam int          ST_DWAIT      = 29;
    localparam int          ST_SRC_LSB    = 2;
    localparam int          ST_SWDONE     = 1;
    localparam int          ST_POR        = 0;
    localparam int          CTL_ENT_SW    = 2;
    localparam int          CTL_BU_SW     = 1;
    localparam int          CTL_GO        = 0;
    localparam int          OVR_TRIG_LSB  = 16;
    localparam logic [31:0] STATUS_RST    = 32'h0000_0001;
    localparam logic [31:0] STATUS_RW1C   = 32'h6000_0FFF;
    localparam logic [31:0] IRQ_EN_MASK   = 32'h6000_0FFF;
    localparam logic [2:0]  CONTROL_RST   = 3'h0;
    localparam logic [9:0]  ENTRY_EN_RST  = 10'h000;
    localparam logic [9:0]  BRINGUP_RST   = 10'h3FF;
    localparam logic [9:0]  MASK_RST      = 10'h000;
    localparam logic [9:0]  OUT_RST       = 10'h000;
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          STEP_DELAY_PS = 100000;
    localparam int          STEP_CYC      =
        (STEP_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          TMR_W         = 8;
endpackage

// file: hdl/rsqsw_sync.sv
// Two-stage synchroniser for the asynchronous reset source inputs
`timescale 1ns/1ps
module rsqsw_sync
    import rsqsw_pkg::*;
#(
    parameter int W = RSQ_NRST
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// file: hdl/rsqsw_top.sv
// Software control part of the reset sequencer: registers, steps, overrides
//
// How it works
// - Stepped bring-up sets the de-asserted-waiting flag at each step enabled in the bring-up enable register
// - Bring-up stepping enables reset to all ones
// - A bring-up wait holds until software clears the waiting flag
// - Override value one asserts an output, zero de-asserts it
// - Override touches only outputs whose trigger bit is set in that write
// - A masked output is not asserted by an assertion sequence
// - Masking never de-asserts an output already asserted
// - Status bit one flags a completed software reset; cleared by one
// - Entry starts on software trigger or any asserted source
// - Interrupt request raised only for enabled events
// - Bring-up starts once entry is done and no source is asserted
// - Stepped entry stops at selected steps, sets bit thirty, interrupts
// - Clearing bit thirty resumes; next selected step interrupts again
// - Stepped bring-up uses the bring-up enable, selection and flag
// - Flags clear on written ones; reset clears all but power-on
// - Status bit thirty-one reads one while a sequence runs
// - Stepped phases ignore the step timer; selected steps wait for software, others advance every cycle
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module rsqsw_top
    import rsqsw_pkg::*;
#(
    parameter int N_RST     = RSQ_NRST,
    parameter int STEP_CYCS = STEP_CYC
) (
    input  wire logic              REF_CLK,
    input  wire logic              SRST,
    input  wire logic [RSQ_AW-1:0] ADDR,
    input  wire logic [RSQ_DW-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [RSQ_DW-1:0] RDATA,
    input  wire logic [N_RST-1:0]  INDEXED_RESET_SOURCE,
    output logic      [N_RST-1:0]  SEQUENCED_RESET_OUTPUT,
    output logic                   IRQ
);
    typedef enum {
        SQ_IDLE,
        SQ_ASRT,
        SQ_AWAIT,
        SQ_HOLD,
        SQ_DSRT,
        SQ_DWAIT
    } rsqsw_state_type;

    localparam logic [3:0]       LAST_IDX = 4'(N_RST - 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(STEP_CYCS - 1);

    function automatic logic hit(input logic [RSQ_AW-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == RSQ_AW'(ofs));
    endfunction

    function automatic logic [N_RST-1:0] one_hot(input logic [3:0] i);
        one_hot = N_RST'(1) << i;
    endfunction

    rsqsw_state_type  st_reg;
    rsqsw_state_type  st_next;
    logic [3:0]       idx_reg;
    logic [3:0]       idx_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;
    logic [31:0]      status_reg;
    logic [31:0]      status_next;
    logic [31:0]      irq_en_reg;
    logic [2:0]       ctl_reg;
    logic [N_RST-1:0] ent_en_reg;
    logic [N_RST-1:0] bu_en_reg;
    logic [N_RST-1:0] mask_reg;
    logic [N_RST-1:0] out_reg;
    logic [N_RST-1:0] out_next;
    logic             sw_pend_reg;
    logic             sw_pend_next;
    logic             irq_reg;
    logic [31:0]      rdata_reg;
    logic [N_RST-1:0] src_sync;
    logic [N_RST-1:0] src_prev_reg;

    rsqsw_sync #(
        .W (N_RST)
    ) u_sync (
        .clk      (REF_CLK),
        .srst     (SRST),
        .async_in (INDEXED_RESET_SOURCE),
        .sync_out (src_sync)
    );

    wire              wr_status = WR && hit(ADDR, OFS_STATUS);
    wire              wr_irq_en = WR && hit(ADDR, OFS_IRQ_EN);
    wire              wr_ctl    = WR && hit(ADDR, OFS_CONTROL);
    wire              wr_ent    = WR && hit(ADDR, OFS_ENTRY_EN);
    wire              wr_bu     = WR && hit(ADDR, OFS_BRINGUP);
    wire              wr_ovr    = WR && hit(ADDR, OFS_OVERRIDE);
    wire              wr_mask   = WR && hit(ADDR, OFS_MASK);
    wire              sw_go     = wr_ctl && WDATA[CTL_GO];
    wire              ent_sw    = ctl_reg[CTL_ENT_SW];
    wire              bu_sw     = ctl_reg[CTL_BU_SW];
    wire              active    = (st_reg != SQ_IDLE);
    wire              tmr_done  = (tmr_reg == '0);
    wire              last_idx  = (idx_reg == LAST_IDX);
    wire [N_RST-1:0]  cur_bit   = one_hot(idx_reg);
    wire [N_RST-1:0]  ovr_trig  = WDATA[OVR_TRIG_LSB +: N_RST];
    wire [N_RST-1:0]  ovr_val   = WDATA[N_RST-1:0];
    wire [N_RST-1:0]  src_rise  = src_sync & ~src_prev_reg;
    wire [31:0]       w1c       = wr_status ? (WDATA & STATUS_RW1C) : '0;
    // Stepped phases skip the timer entirely
    wire              a_go      = ent_sw || tmr_done;
    wire              d_go      = bu_sw || tmr_done;
    wire              a_stop    = ent_sw && ent_en_reg[idx_reg];
    wire              d_stop    = bu_sw && bu_en_reg[idx_reg];
    wire              seq_set   = (st_reg == SQ_ASRT) && a_go;
    wire              seq_clr   = (st_reg == SQ_DSRT) && d_go;

    always_comb begin
        st_next      = st_reg;
        idx_next     = idx_reg;
        tmr_next     = tmr_reg;
        sw_pend_next = sw_pend_reg;
        status_next  = status_reg & ~w1c;
        status_next[ST_SRC_LSB +: N_RST] =
            status_next[ST_SRC_LSB +: N_RST] | src_rise;
        case (st_reg)
            SQ_IDLE: begin
                tmr_next = TMR_LOAD;
                idx_next = '0;
                if (sw_go || (src_sync != '0)) begin
                    st_next      = SQ_ASRT;
                    sw_pend_next = sw_go;
                end
            end
            SQ_ASRT: begin
                if (!a_go) begin
                    tmr_next = tmr_reg - TMR_W'(1);
                end else begin
                    tmr_next = TMR_LOAD;
                    if (a_stop) begin
                        status_next[ST_AWAIT] = 1'b1;
                        st_next = SQ_AWAIT;
                    end else if (last_idx) begin
                        st_next = SQ_HOLD;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                    end
                end
            end
            SQ_AWAIT: begin
                if (!status_reg[ST_AWAIT]) begin
                    if (last_idx) begin
                        st_next = SQ_HOLD;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                        st_next  = SQ_ASRT;
                    end
                end
            end
            SQ_HOLD: begin
                if (src_sync == '0) begin
                    idx_next = '0;
                    st_next  = SQ_DSRT;
                end
            end
            SQ_DSRT: begin
                if (!d_go) begin
                    tmr_next = tmr_reg - TMR_W'(1);
                end else begin
                    tmr_next = TMR_LOAD;
                    if (d_stop) begin
                        status_next[ST_DWAIT] = 1'b1;
                        st_next = SQ_DWAIT;
                    end else if (last_idx) begin
                        st_next = SQ_IDLE;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                    end
                end
            end
            SQ_DWAIT: begin
                if (!status_reg[ST_DWAIT]) begin
                    if (last_idx) begin
                        st_next = SQ_IDLE;
                    end else begin
                        idx_next = idx_reg + 4'h1;
                        st_next  = SQ_DSRT;
                    end
                end
            end
            default: begin
                st_next = SQ_IDLE;
            end
        endcase
        if ((st_reg != SQ_IDLE) && (st_next == SQ_IDLE)) begin
            status_next[ST_SWDONE] = sw_pend_reg | status_next[ST_SWDONE];
            sw_pend_next = 1'b0;
        end
    end

    always_comb begin
        out_next = out_reg;
        if (seq_set && !mask_reg[idx_reg]) begin
            out_next = out_reg | cur_bit;
        end
        if (seq_clr) begin
            out_next = out_reg & ~cur_bit;
        end
        if (wr_ovr) begin
            out_next = (out_next & ~ovr_trig) | (ovr_val & ovr_trig);
        end
    end

    wire [31:0] rd_mux =
        hit(ADDR, OFS_STATUS)   ? {active, status_reg[30:0]} :
        hit(ADDR, OFS_IRQ_EN)   ? irq_en_reg :
        hit(ADDR, OFS_CONTROL)  ? {29'h0, ctl_reg[2:1], 1'b0} :
        hit(ADDR, OFS_ENTRY_EN) ? 32'(ent_en_reg) :
        hit(ADDR, OFS_BRINGUP)  ? 32'(bu_en_reg) :
        hit(ADDR, OFS_MASK)     ? 32'(mask_reg) :
        32'h0;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            st_reg      <= SQ_IDLE;
            idx_reg     <= '0;
            tmr_reg     <= '0;
            sw_pend_reg <= 1'b0;
            status_reg  <= STATUS_RST;
            out_reg     <= OUT_RST;
            irq_reg     <= 1'b0;
            rdata_reg   <= '0;
            src_prev_reg <= '0;
        end else begin
            st_reg      <= st_next;
            idx_reg     <= idx_next;
            tmr_reg     <= tmr_next;
            sw_pend_reg <= sw_pend_next;
            status_reg  <= status_next;
            out_reg     <= out_next;
            irq_reg     <= |(status_reg & irq_en_reg);
            rdata_reg   <= RD ? rd_mux : '0;
            src_prev_reg <= src_sync;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            irq_en_reg <= '0;
            ctl_reg    <= CONTROL_RST;
            ent_en_reg <= ENTRY_EN_RST;
            bu_en_reg  <= BRINGUP_RST;
            mask_reg   <= MASK_RST;
        end else begin
            if (wr_irq_en) begin
                irq_en_reg <= WDATA & IRQ_EN_MASK;
            end
            if (wr_ctl) begin
                ctl_reg <= {WDATA[CTL_ENT_SW], WDATA[CTL_BU_SW], 1'b0};
            end
            if (wr_ent) begin
                ent_en_reg <= WDATA[N_RST-1:0];
            end
            if (wr_bu) begin
                bu_en_reg <= WDATA[N_RST-1:0];
            end
            if (wr_mask) begin
                mask_reg <= WDATA[N_RST-1:0];
            end
        end
    end

    assign RDATA                  = rdata_reg;
    assign SEQUENCED_RESET_OUTPUT = out_reg;
    assign IRQ                    = irq_reg;

    // Checks
    a_bringup_rst_val: assert property (
        @(posedge REF_CLK) $fell(SRST) |-> bu_en_reg == BRINGUP_RST)
        else $error("bring-up enable not all ones after reset");

    a_override_apply: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        wr_ovr |=> ((out_reg & $past(ovr_trig)) ==
                    ($past(ovr_val) & $past(ovr_trig))))
        else $error("override value not applied");

    a_override_keep: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (wr_ovr && !seq_set && !seq_clr) |=>
        ((out_reg & ~$past(ovr_trig)) == ($past(out_reg) & ~$past(ovr_trig))))
        else $error("untriggered output changed");

    a_mask_blocks: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (seq_set && !wr_ovr && mask_reg[idx_reg] && !out_reg[idx_reg])
        |=> !out_reg[$past(idx_reg)])
        else $error("masked output asserted");

    a_no_early_clear: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (!wr_ovr && !seq_clr) |=> (($past(out_reg) & ~out_reg) == '0))
        else $error("output de-asserted outside bring-up");

    a_dwait_holds: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (st_reg == SQ_DWAIT && status_reg[ST_DWAIT]) |=> st_reg == SQ_DWAIT)
        else $error("bring-up advanced while flag set");

    a_await_holds: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (st_reg == SQ_AWAIT && status_reg[ST_AWAIT]) |=> st_reg == SQ_AWAIT)
        else $error("entry advanced while flag set");

    a_entry_flag: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (st_reg == SQ_ASRT && a_go && a_stop) |=>
        (status_reg[ST_AWAIT] && st_reg == SQ_AWAIT))
        else $error("stepped entry did not stop and flag");

    a_entry_start: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (st_reg == SQ_IDLE && (sw_go || src_sync != '0)) |=> st_reg == SQ_ASRT)
        else $error("entry did not start");

    a_bringup_start: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (st_reg == SQ_HOLD && src_sync == '0) |=> st_reg == SQ_DSRT)
        else $error("bring-up did not start");

    a_active_read: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        (RD && hit(ADDR, OFS_STATUS)) |=> RDATA[ST_ACTIVE] == $past(active))
        else $error("active bit wrong");

    a_irq_or: assert property (
        @(posedge REF_CLK) disable iff (SRST)
        ((status_reg & irq_en_reg) != '0) [*2] |-> IRQ)
        else $error("interrupt missing for enabled flag");

    c_entry_step: cover property (
        @(posedge REF_CLK) disable iff (SRST) st_reg == SQ_AWAIT);
    c_bringup_step: cover property (
        @(posedge REF_CLK) disable iff (SRST) st_reg == SQ_DWAIT);
    c_sw_done: cover property (
        @(posedge REF_CLK) disable iff (SRST) $rose(status_reg[ST_SWDONE]));
    c_override: cover property (
        @(posedge REF_CLK) disable iff (SRST) wr_ovr && ovr_trig != '0);
endmodule
